// [rtl/rsd_core.sv]
// receive status capture, receive ring supervision, local and host dma
// pointers. assumes synchronous inputs on sys_clk, a memory that takes
// one request per cycle without stalling, and a mac that never reports
// a byte and a packet end in the same cycle.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rsd_core
  import rsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_start,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  input wire rsd_rx_end_t rx_end_info,
  input wire logic endec_defer,
  input wire logic tx_fetch,
  output logic [15:0] tx_length,
  output logic tx_busy,
  input wire logic xfer_step,
  output logic [15:0] xfer_addr,
  output logic xfer_busy,
  output logic xfer_done,
  output rsd_mem_req_t mem_req,
  output logic rx_abort
);

  rsd_state_t s_q;
  rsd_state_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // ring successor of a page, wrapping at the last page
  function automatic logic [7:0] ring_next(input logic [7:0] page,
                                           input logic [7:0] first,
                                           input logic [7:0] last);
    logic [7:0] inc;
    inc = 8'(page + 8'h01);
    ring_next = (inc == last) ? first : inc;
  endfunction

  // saturating tally; an event in the clearing read cycle is kept
  function automatic logic [7:0] tally(input logic [7:0] cnt,
                                       input logic hit,
                                       input logic clr);
    logic [7:0] t;
    t = cnt;
    if (clr) begin
      t = RSD_BYTE_RESET;
    end
    if (hit) begin
      t = clr ? RSD_TALLY_ONE :
          ((cnt == RSD_TALLY_MAX) ? cnt : 8'(cnt + 8'h01));
    end
    tally = t;
  endfunction

  // ----------------------------------------------------------------
  // combinational view of the receive end report
  // ----------------------------------------------------------------
  logic align_err;
  logic crc_err;
  logic missed;
  logic rx_errored;
  logic keep_pkt;
  logic [7:0] end_status;
  logic [7:0] link_page;
  logic [7:0] after_page;
  logic [7:0] live_status;

  always_comb begin
    // dribble with good crc is still a good frame
    align_err = rx_end_info.dribble & rx_end_info.crc_bad;
    crc_err = rx_end_info.crc_bad;
    missed = rx_end_info.no_buffer | s_q.listen_only | ~s_q.rx_active;
    rx_errored = crc_err | rx_end_info.fifo_over;
    // fifo overrun always aborts, crc errors only when not kept
    keep_pkt = ~missed & ~rx_end_info.fifo_over &
               (~crc_err | s_q.keep_errored);
    end_status = RSD_BYTE_RESET;
    end_status[RSD_ST_CRC] = crc_err;
    end_status[RSD_ST_ALIGN] = align_err;
    end_status[RSD_ST_FIFO] = rx_end_info.fifo_over;
    end_status[RSD_ST_MISSED] = missed;
    end_status[RSD_ST_GROUP] = rx_end_info.group_match;
    end_status[RSD_ST_INTACT] = ~rx_errored & ~missed;
    end_status[RSD_ST_RX_OFF] = s_q.listen_only;
    end_status[RSD_ST_DEFER] = endec_defer;
    link_page = ring_next(s_q.lda[15:8], s_q.first_page, s_q.last_page);
    // a frame whose last byte filled its page has already moved on,
    // so taking the successor again would skip an empty page
    after_page = (s_q.lda[7:0] == RSD_PAGE_OFFSET_ZERO) ? s_q.lda[15:8] :
                 link_page;
  end

  // live bits overlay the captured packet status
  always_comb begin
    live_status = s_q.status;
    live_status[RSD_ST_RX_OFF] = s_q.listen_only;
    live_status[RSD_ST_DEFER] = endec_defer;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.mem = '0;
    s_d.rx_abort = 1'b0;
    s_d.xfer_done = 1'b0;
    s_d.rdata = RSD_BYTE_RESET;

    // register writes, one byte each
    if (reg_wr) begin
      case (reg_addr)
        RSD_CONTROL_OFS: begin
          s_d.word_mode = reg_wdata[RSD_CTL_WORD_MODE];
          s_d.keep_errored = reg_wdata[RSD_CTL_KEEP_ERRORED];
          s_d.listen_only = reg_wdata[RSD_CTL_LISTEN_ONLY];
        end
        RSD_TX_PAGE_START_OFS: s_d.tx_page = reg_wdata;
        RSD_TX_LENGTH_LOW_OFS: s_d.tx_len[7:0] = reg_wdata;
        RSD_TX_LENGTH_HIGH_OFS: s_d.tx_len[15:8] = reg_wdata;
        RSD_RX_RING_FIRST_PAGE_OFS: s_d.first_page = reg_wdata;
        RSD_RX_RING_LAST_PAGE_OFS: s_d.last_page = reg_wdata;
        RSD_RX_RING_GUARD_PAGE_OFS: s_d.guard_page = reg_wdata;
        RSD_RX_WRITE_PAGE_OFS: s_d.write_page = reg_wdata;
        RSD_HOST_XFER_START_LOW_OFS: s_d.xfer_start[7:0] = reg_wdata;
        RSD_HOST_XFER_START_HIGH_OFS: s_d.xfer_start[15:8] = reg_wdata;
        RSD_HOST_XFER_COUNT_LOW_OFS: s_d.xfer_count[7:0] = reg_wdata;
        RSD_HOST_XFER_COUNT_HIGH_OFS: s_d.xfer_count[15:8] = reg_wdata;
        default: begin
        end
      endcase
    end

    // register reads, data valid the next cycle
    if (reg_rd) begin
      case (reg_addr)
        RSD_CONTROL_OFS: begin
          s_d.rdata[RSD_CTL_WORD_MODE] = s_q.word_mode;
          s_d.rdata[RSD_CTL_KEEP_ERRORED] = s_q.keep_errored;
          s_d.rdata[RSD_CTL_LISTEN_ONLY] = s_q.listen_only;
          s_d.rdata[RSD_CTL_TX_BUSY] = s_q.tx_busy;
          s_d.rdata[RSD_CTL_XFER_BUSY] = s_q.xfer_busy;
          s_d.rdata[RSD_CTL_RX_BUSY] = s_q.rx_active;
        end
        RSD_RX_RING_FIRST_PAGE_OFS: s_d.rdata = s_q.first_page;
        RSD_RX_RING_LAST_PAGE_OFS: s_d.rdata = s_q.last_page;
        RSD_RX_RING_GUARD_PAGE_OFS: s_d.rdata = s_q.guard_page;
        RSD_RX_WRITE_PAGE_OFS: s_d.rdata = s_q.write_page;
        RSD_LOCAL_DMA_ADDR_LOW_OFS: s_d.rdata = s_q.lda[7:0];
        RSD_LOCAL_DMA_ADDR_HIGH_OFS: s_d.rdata = s_q.lda[15:8];
        RSD_RX_PACKET_STATUS_OFS: s_d.rdata = live_status;
        RSD_ALIGNMENT_TALLY_OFS: s_d.rdata = s_q.tally_align;
        RSD_CRC_TALLY_OFS: s_d.rdata = s_q.tally_crc;
        RSD_MISSED_TALLY_OFS: s_d.rdata = s_q.tally_missed;
        default: s_d.rdata = RSD_BYTE_RESET;
      endcase
    end

    // tallies clear on read; the event in the same cycle still counts
    s_d.tally_align = tally(s_q.tally_align, rx_end & align_err,
      reg_rd && reg_addr == RSD_ALIGNMENT_TALLY_OFS);
    s_d.tally_crc = tally(s_q.tally_crc, rx_end & crc_err,
      reg_rd && reg_addr == RSD_CRC_TALLY_OFS);
    s_d.tally_missed = tally(s_q.tally_missed, rx_end & missed,
      reg_rd && reg_addr == RSD_MISSED_TALLY_OFS);

    // receive: packet start clears status and, unless listen only, opens the first page
    if (rx_start && !s_q.listen_only) begin
      s_d.status = RSD_BYTE_RESET;
      s_d.rx_active = 1'b1;
      s_d.lda = {s_q.write_page, RSD_FIRST_DATA_OFFSET};
    end else if (rx_start) begin
      s_d.status = RSD_BYTE_RESET;
    end else if (rx_byte_valid && s_q.rx_active) begin
      s_d.mem.we = 1'b1;
      s_d.mem.addr = s_q.lda;
      s_d.mem.wdata = rx_byte;
      s_d.lda = 16'(s_q.lda + RSD_BYTE_STEP);
      if (s_q.lda[7:0] == RSD_PAGE_LAST_BYTE) begin
        // crossing into the next page: refuse to run into the guard
        if (link_page == s_q.guard_page) begin
          s_d.rx_active = 1'b0;
          s_d.rx_abort = 1'b1;
          s_d.lda = {s_q.write_page, RSD_PAGE_OFFSET_ZERO};
        end else begin
          s_d.lda = {link_page, RSD_PAGE_OFFSET_ZERO};
        end
      end
    end else if (rx_end) begin
      s_d.status = end_status;
      s_d.rx_active = 1'b0;
      if (keep_pkt) begin
        // status byte heads the packet in its first page
        s_d.mem.we = 1'b1;
        s_d.mem.addr = {s_q.write_page, RSD_PAGE_OFFSET_ZERO};
        s_d.mem.wdata = end_status;
        s_d.write_page = after_page;
        s_d.lda = {after_page, RSD_PAGE_OFFSET_ZERO};
      end else begin
        // rejected or aborted: rewind so the pages are reused
        s_d.lda = {s_q.write_page, RSD_PAGE_OFFSET_ZERO};
      end
    end else if (reg_wr && reg_addr == RSD_CONTROL_OFS &&
                 reg_wdata[RSD_CTL_TX_GO] && !s_q.rx_active) begin
      // transmit frames always start on a page boundary
      s_d.lda = {s_q.tx_page, RSD_PAGE_OFFSET_ZERO};
      s_d.tx_left = s_q.tx_len;
      s_d.tx_busy = (s_q.tx_len != RSD_WORD_RESET);
    end else if (tx_fetch && s_q.tx_busy) begin
      s_d.mem.re = 1'b1;
      s_d.mem.addr = s_q.lda;
      s_d.lda = 16'(s_q.lda + RSD_BYTE_STEP);
      s_d.tx_left = 16'(s_q.tx_left - RSD_BYTE_STEP);
      s_d.tx_busy = (s_q.tx_left != RSD_BYTE_STEP);
    end

    // host transfer channel
    if (reg_wr && reg_addr == RSD_CONTROL_OFS &&
        reg_wdata[RSD_CTL_XFER_GO]) begin
      s_d.xfer_addr = s_q.xfer_start;
      s_d.xfer_left = s_q.xfer_count;
      s_d.xfer_busy = (s_q.xfer_count != RSD_WORD_RESET);
    end else if (xfer_step && s_q.xfer_busy) begin
      // a word step with one byte left takes the last byte only
      if (s_q.word_mode && s_q.xfer_left != RSD_BYTE_STEP) begin
        s_d.xfer_addr = 16'(s_q.xfer_addr + RSD_WORD_STEP);
        s_d.xfer_left = 16'(s_q.xfer_left - RSD_WORD_STEP);
      end else begin
        s_d.xfer_addr = 16'(s_q.xfer_addr + RSD_BYTE_STEP);
        s_d.xfer_left = 16'(s_q.xfer_left - RSD_BYTE_STEP);
      end
      if (s_d.xfer_left == RSD_WORD_RESET) begin
        s_d.xfer_busy = 1'b0;
        s_d.xfer_done = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign reg_rdata = s_q.rdata;
  assign tx_length = s_q.tx_len;
  assign tx_busy = s_q.tx_busy;
  assign xfer_addr = s_q.xfer_addr;
  assign xfer_busy = s_q.xfer_busy;
  assign xfer_done = s_q.xfer_done;
  assign mem_req = s_q.mem;
  assign rx_abort = s_q.rx_abort;

endmodule

`default_nettype wire

// [shared/rsd_pkg.sv]
// receive status, ring pointers and dma counters: shared definitions
// assumes one clock domain and an 8-bit register port
package rsd_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RSD_CONTROL_OFS = 8'h00;
  localparam logic [7:0] RSD_TX_PAGE_START_OFS = 8'h01;
  localparam logic [7:0] RSD_RX_RING_FIRST_PAGE_OFS = 8'h02;
  localparam logic [7:0] RSD_RX_RING_LAST_PAGE_OFS = 8'h03;
  localparam logic [7:0] RSD_RX_RING_GUARD_PAGE_OFS = 8'h04;
  localparam logic [7:0] RSD_RX_WRITE_PAGE_OFS = 8'h05;
  localparam logic [7:0] RSD_LOCAL_DMA_ADDR_LOW_OFS = 8'h06;
  localparam logic [7:0] RSD_LOCAL_DMA_ADDR_HIGH_OFS = 8'h07;
  localparam logic [7:0] RSD_HOST_XFER_START_LOW_OFS = 8'h08;
  localparam logic [7:0] RSD_HOST_XFER_START_HIGH_OFS = 8'h09;
  localparam logic [7:0] RSD_HOST_XFER_COUNT_LOW_OFS = 8'h0a;
  localparam logic [7:0] RSD_HOST_XFER_COUNT_HIGH_OFS = 8'h0b;
  localparam logic [7:0] RSD_RX_PACKET_STATUS_OFS = 8'h0c;
  localparam logic [7:0] RSD_ALIGNMENT_TALLY_OFS = 8'h0d;
  localparam logic [7:0] RSD_CRC_TALLY_OFS = 8'h0e;
  localparam logic [7:0] RSD_MISSED_TALLY_OFS = 8'h0f;
  localparam logic [7:0] RSD_TX_LENGTH_LOW_OFS = 8'h10;
  localparam logic [7:0] RSD_TX_LENGTH_HIGH_OFS = 8'h11;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // control register
  localparam int RSD_CTL_TX_GO = 0;
  localparam int RSD_CTL_XFER_GO = 1;
  localparam int RSD_CTL_WORD_MODE = 2;
  localparam int RSD_CTL_KEEP_ERRORED = 3;
  localparam int RSD_CTL_LISTEN_ONLY = 4;
  localparam int RSD_CTL_TX_BUSY = 5;
  localparam int RSD_CTL_XFER_BUSY = 6;
  localparam int RSD_CTL_RX_BUSY = 7;
  // receive status byte
  localparam int RSD_ST_INTACT = 0;
  localparam int RSD_ST_CRC = 1;
  localparam int RSD_ST_ALIGN = 2;
  localparam int RSD_ST_FIFO = 3;
  localparam int RSD_ST_MISSED = 4;
  localparam int RSD_ST_GROUP = 5;
  localparam int RSD_ST_RX_OFF = 6;
  localparam int RSD_ST_DEFER = 7;

  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] RSD_BYTE_RESET = 8'h00;
  localparam logic [15:0] RSD_WORD_RESET = 16'h0000;
  localparam logic [7:0] RSD_PAGE_OFFSET_ZERO = 8'h00;
  localparam logic [7:0] RSD_FIRST_DATA_OFFSET = 8'h01;
  localparam logic [7:0] RSD_PAGE_LAST_BYTE = 8'hff;
  localparam logic [15:0] RSD_WORD_STEP = 16'h0002;
  localparam logic [15:0] RSD_BYTE_STEP = 16'h0001;
  localparam logic [7:0] RSD_TALLY_MAX = 8'hff;
  localparam logic [7:0] RSD_TALLY_ONE = 8'h01;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // packet end report from the receive mac
  typedef struct packed {
    logic crc_bad;
    logic dribble;
    logic fifo_over;
    logic no_buffer;
    logic group_match;
  } rsd_rx_end_t;

  // buffer memory request
  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rsd_mem_req_t;

  // whole block state
  typedef struct packed {
    logic [7:0] tx_page;
    logic [15:0] tx_len;
    logic [15:0] tx_left;
    logic tx_busy;
    logic [7:0] first_page;
    logic [7:0] last_page;
    logic [7:0] guard_page;
    logic [7:0] write_page;
    logic [15:0] lda;
    logic rx_active;
    logic [15:0] xfer_start;
    logic [15:0] xfer_count;
    logic [15:0] xfer_addr;
    logic [15:0] xfer_left;
    logic xfer_busy;
    logic word_mode;
    logic keep_errored;
    logic listen_only;
    logic [7:0] status;
    logic [7:0] tally_align;
    logic [7:0] tally_crc;
    logic [7:0] tally_missed;
    logic [7:0] rdata;
    rsd_mem_req_t mem;
    logic rx_abort;
    logic xfer_done;
  } rsd_state_t;

endpackage

// [testbench/rsd_core_asserts.sv]
// port checker for rsd_core: register port, dma requests, transfers
// assumes one clock sys_clk and async active-low rst_n
`timescale 1ns/1ps
`default_nettype none
module rsd_core_asserts
  import rsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_start,
  input wire logic rx_byte_valid,
  input wire logic rx_end,
  input wire logic tx_fetch,
  input wire logic [15:0] tx_length,
  input wire logic tx_busy,
  input wire logic xfer_step,
  input wire logic [15:0] xfer_addr,
  input wire logic xfer_busy,
  input wire logic xfer_done,
  input wire rsd_mem_req_t mem_req,
  input wire logic rx_abort
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  AST_LEN_HOLD: assert property (!reg_wr |=> $stable(tx_length))
    else $error("transmit length moved without a write");
  AST_FETCH_RD: assert property (tx_busy && tx_fetch && !rx_start &&
    !rx_byte_valid && !rx_end && !reg_wr |=> mem_req.re)
    else $error("fetch while busy gave no memory read");
  AST_NO_RD: assert property (!tx_fetch |=> !mem_req.re)
    else $error("memory read without a fetch");
  AST_WE_CAUSE: assert property (mem_req.we |->
    $past(rx_byte_valid) || $past(rx_end))
    else $error("memory write without a receive event");
  AST_STATUS_OFS: assert property ($past(rx_end) && mem_req.we |->
    mem_req.addr[7:0] == 8'h00)
    else $error("status byte not at page offset zero");
  AST_ABORT_PULSE: assert property (rx_abort |=> !rx_abort)
    else $error("ring abort longer than one cycle");
  AST_STEP: assert property (xfer_busy && xfer_step && !reg_wr |=>
    xfer_addr == $past(xfer_addr) + 16'h0001 ||
    xfer_addr == $past(xfer_addr) + 16'h0002)
    else $error("transfer address step not one or two");
  AST_ADDR_HOLD: assert property (!xfer_step && !reg_wr |=>
    $stable(xfer_addr))
    else $error("transfer address moved without a step");
  AST_DONE_PULSE: assert property (xfer_done |=> !xfer_done)
    else $error("transfer done longer than one cycle");
  AST_DONE_IDLE: assert property (xfer_done |->
    !xfer_busy && $past(xfer_busy))
    else $error("transfer done without busy ending");
  // main scenarios reached
  cover property (xfer_done);
  cover property ($past(rx_end) && mem_req.we);
  cover property (rx_abort);
endmodule
bind rsd_core rsd_core_asserts i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_start(rx_start), .rx_byte_valid(rx_byte_valid), .rx_end(rx_end),
  .tx_fetch(tx_fetch), .tx_length(tx_length), .tx_busy(tx_busy),
  .xfer_step(xfer_step), .xfer_addr(xfer_addr), .xfer_busy(xfer_busy),
  .xfer_done(xfer_done), .mem_req(mem_req), .rx_abort(rx_abort));
`default_nettype wire

// [testbench/rsd_mem_model.sv]
// buffer memory on the far side of the local dma port
// assumes one request per cycle; it never stalls, as the dma expects
`timescale 1ns/1ps
`default_nettype none
module rsd_mem_model
  import rsd_pkg::*;
(
  input wire logic sys_clk,
  input wire rsd_mem_req_t mem_req
);
  logic [7:0] mem [0:65535];
  logic [23:0] wq[$];
  logic [15:0] rq[$];
  // store writes and log every access for the bench
  always @(posedge sys_clk) begin
    if (mem_req.we) begin
      mem[mem_req.addr] <= mem_req.wdata;
      wq.push_back({mem_req.addr, mem_req.wdata});
    end
    if (mem_req.re) begin
      rq.push_back(mem_req.addr);
    end
  end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for rsd_core against a behavioural model
// assumes the memory model logs every dma request without stalling
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rsd_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rx_byte = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rx_start = 1'b0, rx_end = 1'b0;
  logic rx_byte_valid = 1'b0, endec_defer = 1'b0, tx_fetch = 1'b0;
  logic xfer_step = 1'b0;
  rsd_rx_end_t rx_end_info = '0, inf;
  logic [7:0] reg_rdata, pg, st, rv;
  logic [15:0] tx_length, xfer_addr, ad;
  logic tx_busy, xfer_busy, xfer_done, rx_abort, c, al, ms, ls, kp, kept;
  rsd_mem_req_t mem_req;
  int n_mismatch = 0, check_count = 0, cyc_n = 0, n_abort = 0;
  int seed = 32'h965d, ta = 0, tc = 0, tm = 0, n, s;
  logic [7:0] rlist[12] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h20};
  rsd_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_start(rx_start),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_end(rx_end),
    .rx_end_info(rx_end_info), .endec_defer(endec_defer),
    .tx_fetch(tx_fetch), .tx_length(tx_length), .tx_busy(tx_busy),
    .xfer_step(xfer_step), .xfer_addr(xfer_addr), .xfer_busy(xfer_busy),
    .xfer_done(xfer_done), .mem_req(mem_req), .rx_abort(rx_abort));
  rsd_mem_model i_mem (.sys_clk(sys_clk), .mem_req(mem_req));
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  // hang guard and abort pulse count
  always @(posedge sys_clk) begin
    cyc_n++;
    if (rx_abort === 1'b1) n_abort++;
    if (cyc_n == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic pkt(input rsd_rx_end_t e, input int nb);
    @(posedge sys_clk);
    rx_start <= 1'b1;
    @(posedge sys_clk);
    rx_start <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= $random(seed);
      @(posedge sys_clk);
    end
    rx_byte_valid <= 1'b0;
    rx_end <= 1'b1;
    rx_end_info <= e;
    @(posedge sys_clk);
    rx_end <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rlist[i]) rd(rlist[i], 8'h00);
    // write page is left for the ring set-up, it is written only once
    for (int a = 2; a < 5; a++) begin
      rv = $random(seed);
      wr(a[7:0], rv);
      rd(a[7:0], rv);
    end
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h00);
    rv = $random(seed);
    wr(8'h10, rv);
    wr(8'h11, ~rv);
    #1;
    chk("tx_length", tx_length, {~rv, rv});
    // ring 0x40..0x47, guard outside it
    wr(8'h02, 8'h40);
    wr(8'h03, 8'h48);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h40);
    rd(8'h05, 8'h40);
    pg = 8'h40;
    for (int k = 0; k < 24; k++) begin
      inf = rsd_rx_end_t'($random(seed));
      kp = $random(seed);
      ls = ($random(seed) & 7) == 0;
      endec_defer <= $random(seed);
      wr(8'h00, {3'b000, ls, kp, 3'b000});
      rd(8'h00, {3'b000, ls, kp, 3'b000});
      pkt(inf, 2);
      c = inf.crc_bad;
      al = c & inf.dribble;
      ms = inf.no_buffer | ls;
      st = {endec_defer, ls, inf.group_match, ms, inf.fifo_over, al, c,
        ~(c | inf.fifo_over | ms)};
      kept = !ms && !inf.fifo_over && (!c || kp);
      ta += al;
      tc += c;
      tm += ms;
      rd(8'h0c, st);
      chk("writes", 16'(i_mem.wq.size()), (ls ? 0 : 2) + kept);
      if (!ls) chk("first", i_mem.wq[0][23:8], {pg, 8'h01});
      if (kept) begin
        chk("st addr", i_mem.wq[$][23:8], {pg, 8'h00});
        chk("st data", {8'h00, i_mem.wq[$][7:0]}, {8'h00, st});
        pg = (pg + 8'h01 == 8'h48) ? 8'h40 : pg + 8'h01;
      end
      rd(8'h05, pg);
      i_mem.wq.delete();
    end
    rd(8'h0d, ta[7:0]);
    rd(8'h0e, tc[7:0]);
    rd(8'h0f, tm[7:0]);
    rd(8'h0e, 8'h00);
    // page crossing into the guard page aborts the packet
    wr(8'h04, (pg + 8'h01 == 8'h48) ? 8'h40 : pg + 8'h01);
    wr(8'h00, 8'h00);
    endec_defer <= 1'b0;
    // a lone packet start wipes the previous status
    @(posedge sys_clk);
    rx_start <= 1'b1;
    @(posedge sys_clk);
    rx_start <= 1'b0;
    rd(8'h0c, 8'h00);
    pkt('0, 256);
    chk("aborts", 16'(n_abort), 16'h0001);
    rd(8'h0c, 8'h10);
    rd(8'h05, pg);
    rd(8'h06, 8'h00);
    rd(8'h07, pg);
    i_mem.wq.delete();
    // transmit fetch of three bytes from a random page
    rv = $random(seed);
    wr(8'h01, rv);
    wr(8'h10, 8'h03);
    wr(8'h11, 8'h00);
    wr(8'h00, 8'h01);
    repeat (3) begin
      @(posedge sys_clk);
      tx_fetch <= 1'b1;
      @(posedge sys_clk);
      tx_fetch <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    #1;
    chk("tx_busy", {15'h0, tx_busy}, 16'h0000);
    chk("reads", 16'(i_mem.rq.size()), 16'h0003);
    foreach (i_mem.rq[i]) chk("rd addr", i_mem.rq[i], {rv, 8'(i)});
    rd(8'h06, 8'h03);
    rd(8'h07, rv);
    // host transfers, byte and word mode
    for (int k = 0; k < 6; k++) begin
      ad = $random(seed);
      n = 1 + ($random(seed) & 7);
      wr(8'h08, ad[7:0]);
      wr(8'h09, ad[15:8]);
      wr(8'h0a, n[7:0]);
      wr(8'h0b, 8'h00);
      wr(8'h00, {5'h00, k[0], 2'b10});
      #1;
      chk("xfer start", xfer_addr, ad);
      while (n > 0) begin
        @(posedge sys_clk);
        xfer_step <= 1'b1;
        @(posedge sys_clk);
        xfer_step <= 1'b0;
        #1;
        s = (k[0] && n > 1) ? 2 : 1;
        ad = ad + 16'(s);
        n = n - s;
        chk("xfer_addr", xfer_addr, ad);
      end
      chk("xfer_done", {15'h0, xfer_done}, 16'h0001);
      chk("xfer_busy", {15'h0, xfer_busy}, 16'h0000);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
